//--- rtl/dmcp_pkg.sv
// Shared constants and carrier types for the converter mode control front end.
// Assumes a single core clock; all users reference names as dmcp_pkg::name.
package dmcp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 8;
  localparam int unsigned ATT_W    = 7;
  localparam int unsigned SAMPLE_W = 20;
  localparam int unsigned SHORT_W  = 16;
  localparam int unsigned CNT_W    = 6;

  // ----------------------------------------------------------------
  // Control word layout, bit n of the word is Bn, B0 shifted first
  // ----------------------------------------------------------------
  localparam int unsigned POS_ATT_FLAG = 0;
  localparam int unsigned POS_ATT_LSB  = 1;
  localparam int unsigned POS_DEEM_B3  = 3;
  localparam int unsigned POS_DEEM_B4  = 4;
  localparam int unsigned POS_DEEM_EN  = 5;
  localparam int unsigned POS_MUTE     = 6;
  localparam int unsigned POS_DUB      = 7;
  localparam int unsigned POS_ZERO     = 4;
  localparam int unsigned POS_WIDTH    = 5;
  localparam int unsigned POS_POL      = 6;
  localparam int unsigned POS_I2S      = 7;
  localparam logic [2:0]  HDR_MODE1    = 3'h1;
  localparam logic [2:0]  HDR_MODE2    = 3'h5;

  // ----------------------------------------------------------------
  // Codes and limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  DEEM_OFF   = 2'h0;
  localparam logic [1:0]  DEEM_48K   = 2'h1;
  localparam logic [1:0]  DEEM_32K   = 2'h2;
  localparam logic [1:0]  DEEM_44K1  = 2'h3;
  localparam logic [6:0]  ATT_MAX    = 7'h7F;
  localparam logic [5:0]  CNT_MAX    = 6'h3F;
  localparam logic [5:0]  I2S_FIRST  = 6'h01;
  localparam logic [5:0]  I2S_LAST   = 6'h10;
  localparam logic [2:0]  SETTLE_CNT = 3'h4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] deem_code;
    logic       deem_en;
    logic       mute;
    logic       dubbing;
    logic       zero_det;
    logic       width20;
    logic       polarity;
    logic       i2s;
    logic [6:0] atten;
  } dmcp_cfg_t;

  typedef struct packed {
    logic mode;
    logic sel_a;
    logic sel_b;
    logic latch_n;
    logic mute_n;
    logic ratio;
    logic frame;
    logic bitclk;
    logic data;
  } dmcp_pins_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam dmcp_cfg_t CFG_RST = '{
    deem_code: DEEM_44K1, deem_en: 1'h0, mute: 1'h0, dubbing: 1'h0,
    zero_det: 1'h1, width20: 1'h0, polarity: 1'h0, i2s: 1'h0, atten: 7'h00};
  localparam logic [8:0]  PINS_RST = 9'h030;
  localparam logic [7:0]  WORD_RST = 8'hFF;

endpackage

//--- rtl/dmcp_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous levels; output moves when stages two and three agree.
`timescale 1ns/1ps
module dmcp_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } dmcp_sync_st_t;

  dmcp_sync_st_t st_reg;
  dmcp_sync_st_t st_next;

  if (W < 1)
  begin : g_bad_width
    $error("dmcp_sync width must be at least one");
  end

  // ----------------------------------------------------------------
  // Logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = i_async;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    // Only s2 and s3 are compared; s1 may be metastable
    st_next.filt = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) |
                   (st_reg.filt & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, filt: RST_VAL};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.filt;

endmodule // dmcp_sync

//--- rtl/dmcp_shift.sv
// Link-domain shift register for the serial control word.
// Assumes the host stops the shift clock before it pulses the latch strobe.
`timescale 1ns/1ps
module dmcp_shift (
  input  wire logic       i_link_clk,
  input  wire logic       i_serial_in,
  output logic      [7:0] o_word
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] word;
  } dmcp_shift_st_t;

  dmcp_shift_st_t st_reg;
  dmcp_shift_st_t st_next;

  // ----------------------------------------------------------------
  // Logic
  // ----------------------------------------------------------------
  always_comb
  begin
    // First bit ends at bit 0 after eight edges
    st_next.word = {i_serial_in, st_reg.word[7:1]};
  end

  // No reset: clock only runs inside a frame, word is data only
  always_ff @(posedge i_link_clk)
  begin
    st_reg <= st_next;
  end

  assign o_word = st_reg.word;

endmodule // dmcp_shift

//--- rtl/dmcp_mode_ctrl.sv
// Mode control front end: serial control port, parallel pins, attenuation
// ramp and audio input framing.
// Assumes pins are asynchronous to i_core_clk and the shift clock is a separate domain.
`timescale 1ns/1ps
module dmcp_mode_ctrl (
  input  wire logic                i_core_clk,
  input  wire logic                i_srst,
  input  wire logic                i_ctrl_shift_clock,
  input  wire logic                i_ctrl_serial_in,
  input  wire logic                i_ctrl_latch_strobe_n,
  input  wire logic                i_mode_select,
  input  wire logic                i_mute_n,
  input  wire logic                i_sysclk_ratio_select,
  input  wire logic                i_frame_clock_in,
  input  wire logic                i_bit_clock_in,
  input  wire logic                i_audio_data_in,
  output dmcp_pkg::dmcp_cfg_t      o_cfg,
  output logic               [6:0] o_gain,
  output logic              [19:0] o_left,
  output logic              [19:0] o_right,
  output logic                     o_sample_valid,
  output logic                     o_double_speed,
  output logic                     o_serial_mode,
  output logic                     o_word_applied
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dmcp_pkg::dmcp_cfg_t ser;
    dmcp_pkg::dmcp_cfg_t cfg;
    logic [6:0]          eff_level;
    logic [6:0]          gain;
    logic                bclk_prev;
    logic                frame_last;
    logic [5:0]          bit_cnt;
    logic [19:0]         shreg;
    logic [19:0]         left;
    logic [19:0]         right;
    logic                valid;
    logic                dub_out;
    logic                ser_mode;
    logic                applied;
    logic [2:0]          settle;
  } dmcp_core_t;

  localparam dmcp_core_t CORE_RST = '{
    ser:        dmcp_pkg::CFG_RST,
    cfg:        dmcp_pkg::CFG_RST,
    eff_level:  7'h00,
    gain:       dmcp_pkg::ATT_MAX,
    bclk_prev:  1'h0,
    frame_last: 1'h0,
    bit_cnt:    6'h00,
    shreg:      20'h00000,
    left:       20'h00000,
    right:      20'h00000,
    valid:      1'h0,
    dub_out:    1'h0,
    ser_mode:   1'h0,
    applied:    1'h0,
    settle:     3'h0};

  dmcp_core_t           st_reg;
  dmcp_core_t           st_next;
  dmcp_pkg::dmcp_pins_t pins_raw;
  dmcp_pkg::dmcp_pins_t pins;
  logic [7:0]           link_word;
  logic [7:0]           word;

  // ----------------------------------------------------------------
  // Link domain and crossings
  // ----------------------------------------------------------------
  dmcp_shift u_shift (
    .i_link_clk  (i_ctrl_shift_clock),
    .i_serial_in (i_ctrl_serial_in),
    .o_word      (link_word)
  );

  // Word is quiet while the latch is low, so a filtered bus crossing suffices
  dmcp_sync #(
    .W       (dmcp_pkg::WORD_W),
    .RST_VAL (dmcp_pkg::WORD_RST)
  ) u_word_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    (link_word),
    .o_level    (word)
  );

  assign pins_raw = '{
    mode:    i_mode_select,
    sel_a:   i_ctrl_serial_in,
    sel_b:   i_ctrl_shift_clock,
    latch_n: i_ctrl_latch_strobe_n,
    mute_n:  i_mute_n,
    ratio:   i_sysclk_ratio_select,
    frame:   i_frame_clock_in,
    bitclk:  i_bit_clock_in,
    data:    i_audio_data_in};

  dmcp_sync #(
    .W       ($bits(dmcp_pkg::dmcp_pins_t)),
    .RST_VAL (dmcp_pkg::PINS_RST)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    (pins_raw),
    .o_level    (pins)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    dmcp_pkg::dmcp_cfg_t eff;
    logic [6:0]          target;
    logic [5:0]          cnt_this;
    logic [19:0]         sample;
    logic                boundary;
    logic                left_ch;
    logic                take_bit;
    eff      = st_reg.cfg;
    target   = 7'h00;
    cnt_this = 6'h00;
    sample   = 20'h00000;
    boundary = 1'h0;
    left_ch  = 1'h0;
    take_bit = 1'h0;
    st_next         = st_reg;
    st_next.valid   = 1'h0;
    st_next.applied = 1'h0;

    // Serial words: held in the link shift register until latch goes low
    if (pins.mode && !pins.latch_n)
    begin
      st_next.applied = 1'h1;
      if (!word[dmcp_pkg::POS_ATT_FLAG])
      begin
        st_next.ser.atten = word[dmcp_pkg::POS_ATT_LSB +: dmcp_pkg::ATT_W];
      end
      else if (word[2:0] == dmcp_pkg::HDR_MODE1)
      begin
        st_next.ser.deem_code = {word[dmcp_pkg::POS_DEEM_B3],
                                 word[dmcp_pkg::POS_DEEM_B4]};
        st_next.ser.deem_en   = word[dmcp_pkg::POS_DEEM_EN];
        st_next.ser.mute      = word[dmcp_pkg::POS_MUTE];
        st_next.ser.dubbing   = word[dmcp_pkg::POS_DUB];
      end
      else if (word[2:0] == dmcp_pkg::HDR_MODE2)
      begin
        // B3 carries nothing here
        st_next.ser.zero_det = word[dmcp_pkg::POS_ZERO];
        st_next.ser.width20  = word[dmcp_pkg::POS_WIDTH];
        st_next.ser.polarity = word[dmcp_pkg::POS_POL];
        st_next.ser.i2s      = word[dmcp_pkg::POS_I2S];
      end
      else
      begin
        st_next.applied = 1'h0;
      end
    end

    // Effective configuration
    if (pins.mode)
    begin
      eff      = st_reg.ser;
      eff.mute = st_reg.ser.mute | ~pins.mute_n;
      // I2S framing carries only 16 bits
      eff.i2s  = st_reg.ser.i2s & ~st_reg.ser.width20;
    end
    else
    begin
      eff           = dmcp_pkg::CFG_RST;
      eff.deem_code = {pins.sel_a, pins.sel_b};
      eff.deem_en   = ({pins.sel_a, pins.sel_b} != dmcp_pkg::DEEM_OFF);
      eff.mute      = ~pins.mute_n;
      eff.dubbing   = ~pins.latch_n;
    end
    // Pin filters start at reset levels; keep defaults until they follow the pins
    if (st_reg.settle != dmcp_pkg::SETTLE_CNT)
    begin
      st_next.settle = st_reg.settle + 3'h1;
    end
    else
    begin
      st_next.cfg      = eff;
      st_next.ser_mode = pins.mode;
      // Dubbing needs the 384 ratio; blocked at 256 rather than run wrong
      st_next.dub_out  = eff.dubbing & pins.ratio;
    end

    // Audio framing, sampled on filtered bit clock rise
    st_next.bclk_prev = pins.bitclk;
    if (pins.bitclk && !st_reg.bclk_prev)
    begin
      boundary           = (pins.frame != st_reg.frame_last);
      st_next.frame_last = pins.frame;
      if (boundary)
      begin
        cnt_this = 6'h00;
      end
      else if (st_reg.bit_cnt != dmcp_pkg::CNT_MAX)
      begin
        cnt_this = st_reg.bit_cnt + 6'h01;
      end
      else
      begin
        cnt_this = st_reg.bit_cnt;
      end
      st_next.bit_cnt = cnt_this;
      // I2S keeps bits 1..16 after the edge; right-justified keeps the tail
      take_bit = !st_reg.cfg.i2s ||
                 ((cnt_this >= dmcp_pkg::I2S_FIRST) && (cnt_this <= dmcp_pkg::I2S_LAST));
      if (boundary)
      begin
        sample  = st_reg.cfg.width20 ? st_reg.shreg : {st_reg.shreg[15:0], 4'h0};
        left_ch = st_reg.frame_last ^ st_reg.cfg.polarity ^ st_reg.cfg.i2s;
        st_next.valid = 1'h1;
        if (left_ch)
        begin
          st_next.left = sample;
          // One ramp step per sample period, so 127 steps is full mute
          target = st_reg.cfg.mute ? dmcp_pkg::ATT_MAX : st_reg.cfg.atten;
          if (st_reg.eff_level < target)
          begin
            st_next.eff_level = st_reg.eff_level + 7'h01;
          end
          else if (st_reg.eff_level > target)
          begin
            st_next.eff_level = st_reg.eff_level - 7'h01;
          end
        end
        else
        begin
          st_next.right = sample;
        end
      end
      if (take_bit)
      begin
        st_next.shreg = {st_reg.shreg[18:0], pins.data};
      end
    end

    // Linear gain numerator over 127; zero at level 127
    st_next.gain = dmcp_pkg::ATT_MAX - st_next.eff_level;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st_reg <= CORE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_cfg          = st_reg.cfg;
  assign o_gain         = st_reg.gain;
  assign o_left         = st_reg.left;
  assign o_right        = st_reg.right;
  assign o_sample_valid = st_reg.valid;
  assign o_double_speed = st_reg.dub_out;
  assign o_serial_mode  = st_reg.ser_mode;
  assign o_word_applied = st_reg.applied;

endmodule // dmcp_mode_ctrl

//--- verif/dmcp_mode_ctrl_props.sv
// Concurrent checks on the mode control front end ports.
// Assumes binding onto dmcp_mode_ctrl; one core clock domain.
`timescale 1ns/1ps
module dmcp_mode_ctrl_props (
  input wire logic                i_core_clk,
  input wire logic                i_srst,
  input wire logic                i_ctrl_shift_clock,
  input wire logic                i_ctrl_serial_in,
  input wire logic                i_ctrl_latch_strobe_n,
  input wire logic                i_mode_select,
  input wire logic                i_mute_n,
  input wire logic                i_sysclk_ratio_select,
  input wire dmcp_pkg::dmcp_cfg_t o_cfg,
  input wire logic                o_sample_valid,
  input wire logic                o_double_speed,
  input wire logic                o_serial_mode,
  input wire logic                o_word_applied
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Pins must settle first: the filters add several cycles
  sequence par_settled;
    (!i_mode_select && $stable({i_ctrl_serial_in, i_ctrl_shift_clock,
      i_ctrl_latch_strobe_n}))[*8];
  endsequence
  sequence ser_idle;
    (i_ctrl_latch_strobe_n && i_mode_select && o_serial_mode && i_mute_n)[*8];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rst_cfg_a: assert property ($fell(i_srst) |-> o_cfg == dmcp_pkg::CFG_RST)
    else $error("config not at reset value");
  mode_sel_a: assert property (i_mode_select[*8] |-> o_serial_mode)
    else $error("serial mode not taken");
  par_fixed_a: assert property (par_settled |=> ##1 !o_cfg.width20 && !o_cfg.i2s
    && !o_cfg.polarity && o_cfg.atten == 7'h00) else $error("parallel fixed fields wrong");
  par_deem_a: assert property (par_settled |=> ##1
    o_cfg.deem_code == $past({i_ctrl_serial_in, i_ctrl_shift_clock}, 2))
    else $error("parallel de-emphasis decode wrong");
  par_dub_a: assert property (par_settled |=> ##1
    o_cfg.dubbing == !$past(i_ctrl_latch_strobe_n, 2)) else $error("parallel dubbing wrong");
  dub_gate_a: assert property ((!i_sysclk_ratio_select)[*8] |-> !o_double_speed)
    else $error("double speed at low ratio");
  latch_hold_a: assert property (ser_idle |=> $stable(o_cfg))
    else $error("config moved without latch");
  applied_a: assert property (i_ctrl_latch_strobe_n[*8] |-> !o_word_applied)
    else $error("word applied without latch");
  width_i2s_a: assert property (o_cfg.width20 |-> !o_cfg.i2s)
    else $error("i2s with 20-bit width");
  valid_a: assert property (o_sample_valid |=> !o_sample_valid)
    else $error("sample valid longer than a cycle");
endmodule // dmcp_mode_ctrl_props

bind dmcp_mode_ctrl dmcp_mode_ctrl_props i_props (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_ctrl_shift_clock(i_ctrl_shift_clock), .i_ctrl_serial_in(i_ctrl_serial_in),
  .i_ctrl_latch_strobe_n(i_ctrl_latch_strobe_n), .i_mode_select(i_mode_select),
  .i_mute_n(i_mute_n), .i_sysclk_ratio_select(i_sysclk_ratio_select), .o_cfg(o_cfg),
  .o_sample_valid(o_sample_valid), .o_double_speed(o_double_speed),
  .o_serial_mode(o_serial_mode), .o_word_applied(o_word_applied));

//--- verif/dmcp_host_model.sv
// Host side of the three-wire control port, also drives the static pins.
// Assumes a 15 ns shift clock that stands still between words.
`timescale 1ns/1ps
module dmcp_host_model (
  output logic o_shift_clk,
  output logic o_serial,
  output logic o_latch_n
);
  initial
  begin
    o_shift_clk = 1'b0;
    o_serial    = 1'b0;
    o_latch_n   = 1'b1;
  end
  task automatic send(input logic [7:0] w, input bit do_latch);
    for (int i = 0; i < 8; i++)
    begin
      o_serial = w[i];
      #7.5 o_shift_clk = 1'b1;
      #7.5 o_shift_clk = 1'b0;
    end
    // Released line: no pull, so show the inverse of the last bit
    o_serial = ~w[7];
    if (do_latch)
    begin
      #50 o_latch_n = 1'b0;
      #250 o_latch_n = 1'b1;
    end
    #400;
  endtask
  task automatic set_pins(input logic a, input logic b, input logic l);
    o_serial    <= a;
    o_shift_clk <= b;
    o_latch_n   <= l;
  endtask
endmodule // dmcp_host_model

//--- verif/tb_top.sv
// Self-checking bench: serial words, parallel pins and audio framing.
// Assumes the host model owns the three shared control pins.
`timescale 1ns/1ps
module tb_top;
  logic                i_core_clk;
  logic                i_srst;
  logic                i_mode_select;
  logic                i_mute_n;
  logic                i_ratio;
  logic                frm;
  logic                bck;
  logic                din;
  wire logic           mc;
  wire logic           md;
  wire logic           ml;
  dmcp_pkg::dmcp_cfg_t o_cfg;
  dmcp_pkg::dmcp_cfg_t exp;
  logic [6:0]          o_gain;
  logic [19:0]         o_left;
  logic [19:0]         o_right;
  logic                vld;
  logic                dbl;
  logic                smode;
  logic                app;
  int                  n_errors;
  int                  n_tests;
  int                  n_app = 0;
  int                  n_vld = 0;
  int                  app_base;
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  dmcp_host_model i_host (.o_shift_clk(mc), .o_serial(md), .o_latch_n(ml));
  dmcp_mode_ctrl i_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ctrl_shift_clock(mc),
    .i_ctrl_serial_in(md), .i_ctrl_latch_strobe_n(ml), .i_mode_select(i_mode_select),
    .i_mute_n(i_mute_n), .i_sysclk_ratio_select(i_ratio), .i_frame_clock_in(frm),
    .i_bit_clock_in(bck), .i_audio_data_in(din), .o_cfg(o_cfg), .o_gain(o_gain),
    .o_left(o_left), .o_right(o_right), .o_sample_valid(vld), .o_double_speed(dbl),
    .o_serial_mode(smode), .o_word_applied(app));
  // Tallies of high cycles: vld lasts one cycle, app stays high while the latch is low and the word is recognised; read before the edge updates them
  always @(posedge i_core_clk)
  begin
    if (app === 1'b1)
      n_app <= n_app + 1;
    if (vld === 1'b1)
      n_vld <= n_vld + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for the filtered path, then compare
  task automatic cfg_check();
    for (int k = 0; k < 40; k++)
    begin
      if (o_cfg === exp)
        break;
      @(posedge i_core_clk);
    end
    check(32'(o_cfg), 32'(exp));
  endtask
  task automatic mode1(input logic [1:0] c, input logic en, input logic mu, input logic db);
    i_host.send({db, mu, en, c[0], c[1], 3'h1}, 1'b1);
    exp.deem_code = c;
    exp.deem_en   = en;
    exp.mute      = mu;
    exp.dubbing   = db;
    cfg_check();
  endtask
  task automatic mode2(input logic z, input logic w, input logic p, input logic s);
    i_host.send({s, p, w, z, 4'h5}, 1'b1);
    exp.zero_det = z;
    exp.width20  = w;
    exp.polarity = p;
    exp.i2s      = s & ~w;
    cfg_check();
  endtask
  task automatic atten(input logic [6:0] lvl);
    i_host.send({lvl, 1'b0}, 1'b1);
    exp.atten = lvl;
    cfg_check();
  endtask
  // Left word with frame high, bit clock slow against the core clock
  task automatic audio(input logic [15:0] l, input logic [15:0] r);
    for (int i = 31; i >= 0; i--)
    begin
      frm <= (i > 15);
      din <= (i > 15) ? l[i-16] : r[i];
      repeat (5) @(posedge i_core_clk);
      bck <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      bck <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    i_srst = 1'b1;
    i_mode_select = 1'b1;
    i_mute_n = 1'b1;
    i_ratio = 1'b1;
    frm = 1'b0;
    bck = 1'b0;
    din = 1'b0;
    exp = dmcp_pkg::CFG_RST;
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    check(32'(o_cfg), 32'(exp));
    check(32'(o_gain), 32'h7F);
    check(32'(smode), 32'h1);
    i_host.send(8'hE1, 1'b0);
    repeat (20) @(posedge i_core_clk);
    check(32'(o_cfg), 32'(exp));
    check(32'(n_app), 32'h0);
    for (int i = 0; i < 4; i++)
      mode1(i[1:0], ~i[0], i[1], i[0]);
    check(32'(n_app > 0), 32'h1);
    app_base = n_app;
    i_host.send(8'hFF, 1'b1);
    repeat (20) @(posedge i_core_clk);
    check(32'(o_cfg), 32'(exp));
    check(32'(n_app), 32'(app_base));
    mode2(1'b0, 1'b1, 1'b1, 1'b1);
    mode2(1'b1, 1'b0, 1'b0, 1'b1);
    mode2(1'b1, 1'b0, 1'b0, 1'b0);
    mode1(2'h3, 1'b0, 1'b0, 1'b0);
    atten(7'h01);
    audio(16'hA5C3, 16'h1234);
    audio(16'h5A3C, 16'h8001);
    audio(16'hF00F, 16'h0FF0);
    repeat (10) @(posedge i_core_clk);
    check(32'(o_left), 32'hF00F0);
    check(32'(o_right), 32'h80010);
    check(32'(o_gain), 32'h7E);
    check(32'(n_vld), 32'h6);
    atten(7'h7F);
    // Parallel mode: same three pins become static levels
    i_mode_select <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      i_host.set_pins(i[1], i[0], i[2]);
      exp = '{deem_code: i[1:0], deem_en: |i[1:0], mute: 1'b0, dubbing: ~i[2],
        zero_det: 1'b1, width20: 1'b0, polarity: 1'b0, i2s: 1'b0, atten: 7'h00};
      cfg_check();
      check(32'(dbl), 32'(~i[2] & 1'b1));
      repeat (10) @(posedge i_core_clk);
    end
    check(32'(smode), 32'h0);
    i_ratio <= 1'b0;
    repeat (12) @(posedge i_core_clk);
    check(32'(dbl), 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
